// >>> inc/mabs_pkg.sv
// shared constants and types of the alu and branch datapath
package mabs_pkg;

  // ==========================================================
  // status flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;

  // ==========================================================
  // flag update masks and reset values
  localparam logic [7:0] MASK_ARITH = 8'h2f;
  localparam logic [7:0] MASK_WORD  = 8'h1f;
  localparam logic [7:0] MASK_LOGIC = 8'h0e;
  localparam logic [7:0] MASK_FULL  = 8'hff;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ==========================================================
  // clock counts per operation class
  localparam logic [1:0] CYC_ALU   = 2'h1;
  localparam logic [1:0] CYC_WORD  = 2'h2;
  localparam logic [1:0] CYC_JUMP  = 2'h2;
  localparam logic [1:0] CYC_CALL  = 2'h3;
  localparam logic [1:0] CYC_IOBIT = 2'h2;
  localparam logic [1:0] CYC_SKIP1 = 2'h2;
  localparam logic [1:0] CYC_SKIP2 = 2'h3;

  // ==========================================================
  // register file and i/o space
  localparam logic [4:0] PTR_LO_IDX = 5'h1e;
  localparam logic [4:0] PTR_HI_IDX = 5'h1f;
  localparam logic [5:0] IO_BIT_MAX = 6'h1f;

  // ==========================================================
  // operations
  typedef enum logic [4:0] {
    MABS_OP_NOP          = 5'h00,
    MABS_OP_ADD          = 5'h01,
    MABS_OP_ADD_CARRY    = 5'h02,
    MABS_OP_WORD_ADD_IMM = 5'h03,
    MABS_OP_MINUS        = 5'h04,
    MABS_OP_MINUS_IMM    = 5'h05,
    MABS_OP_MINUS_BORROW = 5'h06,
    MABS_OP_MINUS_IMM_BR = 5'h07,
    MABS_OP_WORD_MINUS   = 5'h08,
    MABS_OP_AND          = 5'h09,
    MABS_OP_AND_IMM      = 5'h0a,
    MABS_OP_OR           = 5'h0b,
    MABS_OP_OR_IMM       = 5'h0c,
    MABS_OP_XOR          = 5'h0d,
    MABS_OP_SET_MASK     = 5'h0e,
    MABS_OP_CLEAR_MASK   = 5'h0f,
    MABS_OP_ZERO_CHECK   = 5'h10,
    MABS_OP_REL_CALL     = 5'h11,
    MABS_OP_PTR_JUMP     = 5'h12,
    MABS_OP_PTR_CALL     = 5'h13,
    MABS_OP_EQUAL_SKIP   = 5'h14,
    MABS_OP_COMPARE      = 5'h15,
    MABS_OP_COMPARE_C    = 5'h16,
    MABS_OP_COMPARE_IMM  = 5'h17,
    MABS_OP_IO_BIT_SET   = 5'h18,
    MABS_OP_IO_BIT_CLEAR = 5'h19,
    MABS_OP_SKIP_IO_HIGH = 5'h1a,
    MABS_OP_SKIP_IO_LOW  = 5'h1b
  } mabs_op_type;

  typedef enum logic [0:0] {
    MABS_IDLE = 1'b0,
    MABS_WAIT = 1'b1
  } mabs_state_type;

endpackage

// >>> hdl/mabs_alu8.sv
// eight bit add and subtract unit with status flags
`timescale 1ns/1ns
module mabs_alu8 (
  // operands
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic       carryIn,
  input  wire logic       doSub,
  // zero chaining for borrow forms
  input  wire logic       chainZero,
  input  wire logic       zeroPrev,
  // results
  output logic      [7:0] result,
  output logic            flagH,
  output logic            flagV,
  output logic            flagN,
  output logic            flagZ,
  output logic            flagC
);

  logic [8:0] sum;

  // ==========================================================
  // arithmetic and flag terms
  always_comb begin
    if (doSub) begin
      sum   = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
      result = sum[7:0];
      flagH = (~opA[3] & opB[3]) | (opB[3] & result[3]) | (result[3] & ~opA[3]);
      flagC = (~opA[7] & opB[7]) | (opB[7] & result[7]) | (result[7] & ~opA[7]);
      flagV = (opA[7] & ~opB[7] & ~result[7]) | (~opA[7] & opB[7] & result[7]);
    end else begin
      sum   = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
      result = sum[7:0];
      flagH = (opA[3] & opB[3]) | (opB[3] & ~result[3]) | (~result[3] & opA[3]);
      flagC = sum[8];
      flagV = (opA[7] & opB[7] & ~result[7]) | (~opA[7] & ~opB[7] & result[7]);
    end
    flagN = result[7];
    flagZ = (result == 8'h00) & (~chainZero | zeroPrev);
  end

endmodule

// >>> hdl/mabs_core.sv
// execution datapath for arithmetic, logic, compare and branch operations
`timescale 1ns/1ns
// Function
// - add and add-with-carry write sum, set Z C N V H, one clock
// - word add immediate updates register pair, sets Z C N V S, two clocks
// - subtract register or immediate stores difference, sets Z C N V H, one clock
// - subtract with borrow also subtracts carry, same five flags, one clock
// - word subtract immediate works on whole pair, sets Z C N V S, two clocks
// - and with register or immediate stores result, sets Z N V, one clock
// - or with register or immediate stores result, sets Z N V, one clock
// - exclusive or of two registers stores result, sets Z N V, one clock
// - clear mask ands destination with mask inverted against all ones, one clock
// - set mask ors mask into destination, sets Z N V, one clock
// - test ands register with itself, value unchanged, sets Z N V, one clock
// - relative call loads pc plus offset plus one, three clocks
// - pointer jump loads pc from pointer pair, flags unchanged, two clocks
// - pointer call targets pointer pair, flags unchanged, three clocks
// - equal skip advances pc by one, two or three, no flags, one to three clocks
// - compares discard difference, set Z N V C H only, one clock
// - i/o bit set and clear act only on addresses 0x00 to 0x1f
// - i/o bit skips test any bit inside the bit-accessible range
// - some i/o status flags clear when written with a one
// - i/o bit set and clear touch only the addressed bit
module mabs_core #(
  parameter int unsigned PC_W = 12
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // operation issue
  input  wire logic                      opValid,
  input  wire mabs_pkg::mabs_op_type     opCode,
  input  wire logic [4:0]                dstIdx,
  input  wire logic [4:0]                srcIdx,
  input  wire logic [7:0]                immK,
  input  wire logic [PC_W-1:0]           relOffset,
  input  wire logic [5:0]                ioAddr,
  input  wire logic [2:0]                ioBit,
  input  wire logic [7:0]                ioOperand,
  input  wire logic                      nextTwoWord,
  // register file load and read
  input  wire logic                      loadEn,
  input  wire logic [4:0]                loadIdx,
  input  wire logic [7:0]                loadData,
  input  wire logic [4:0]                rdIdx,
  output logic      [7:0]                rdData,
  // status
  output logic                           busy,
  output logic                           done,
  output logic      [PC_W-1:0]           pc,
  output logic      [7:0]                status,
  // return address push
  output logic                           pushEn,
  output logic      [PC_W-1:0]           pushAddr,
  // i/o single bit write
  output logic                           ioWrEn,
  output logic      [5:0]                ioWrAddr,
  output logic      [7:0]                ioWrMask,
  output logic      [7:0]                ioWrData
);

  typedef struct packed {
    logic            wrEn;
    logic            wordEn;
    logic [4:0]      idx;
    logic [15:0]     val;
    logic [7:0]      flagMask;
    logic [7:0]      flags;
    logic [PC_W-1:0] pc;
    logic            push;
    logic [PC_W-1:0] pushAddr;
    logic            ioEn;
    logic [5:0]      ioAddr;
    logic [7:0]      ioMask;
    logic [7:0]      ioData;
    logic [1:0]      cyc;
  } mabs_pend_type;

  typedef struct packed {
    mabs_pkg::mabs_state_type st;
    logic [1:0]               cnt;
    logic [31:0][7:0]         regs;
    logic [PC_W-1:0]          pc;
    logic [7:0]               sreg;
    mabs_pend_type            pend;
    logic                     busy;
    logic                     done;
    logic [7:0]               rdData;
    logic                     pushEn;
    logic [PC_W-1:0]          pushAddr;
    logic                     ioWrEn;
    logic [5:0]               ioWrAddr;
    logic [7:0]               ioWrMask;
    logic [7:0]               ioWrData;
  } mabs_core_type;

  mabs_core_type q;
  mabs_core_type d;
  mabs_pend_type ex;
  mabs_pend_type src;
  logic          accept;
  logic          commit;
  logic [7:0]    aluA;
  logic [7:0]    aluB;
  logic          aluCin;
  logic          aluSub;
  logic          aluChain;
  logic [7:0]    aluRes;
  logic          aluH;
  logic          aluV;
  logic          aluN;
  logic          aluZ;
  logic          aluC;
  logic [7:0]    logicRes;
  logic [15:0]   wordIn;
  logic [16:0]   wordSum;
  logic [15:0]   ptrVal;
  logic          ioInRange;
  logic          skipTaken;
  logic [PC_W-1:0] pcInc;

  // ==========================================================
  // helpers
  function automatic logic [7:0] packFlags(input logic h, input logic s, input logic v,
                                           input logic n, input logic z, input logic c);
    logic [7:0] f;
    f = 8'h00;
    f[mabs_pkg::FLAG_H] = h;
    f[mabs_pkg::FLAG_S] = s;
    f[mabs_pkg::FLAG_V] = v;
    f[mabs_pkg::FLAG_N] = n;
    f[mabs_pkg::FLAG_Z] = z;
    f[mabs_pkg::FLAG_C] = c;
    return f;
  endfunction

  function automatic logic [7:0] logicFlags(input logic [7:0] r);
    return packFlags(1'b0, 1'b0, 1'b0, r[7], r == 8'h00, 1'b0);
  endfunction

  // ==========================================================
  // operand selection
  assign accept    = opValid & (q.st == mabs_pkg::MABS_IDLE);
  assign aluA      = q.regs[dstIdx];
  assign wordIn    = {q.regs[5'(dstIdx + 5'h01)], q.regs[dstIdx]};
  assign ptrVal    = {q.regs[mabs_pkg::PTR_HI_IDX], q.regs[mabs_pkg::PTR_LO_IDX]};
  assign ioInRange = ioAddr <= mabs_pkg::IO_BIT_MAX;
  assign pcInc     = PC_W'(q.pc + 1'b1);

  always_comb begin
    aluB     = q.regs[srcIdx];
    aluCin   = 1'b0;
    aluSub   = 1'b1;
    aluChain = 1'b0;
    case (opCode)
      mabs_pkg::MABS_OP_ADD: begin
        aluSub = 1'b0;
      end
      mabs_pkg::MABS_OP_ADD_CARRY: begin
        aluSub = 1'b0;
        aluCin = q.sreg[mabs_pkg::FLAG_C];
      end
      mabs_pkg::MABS_OP_MINUS_IMM,
      mabs_pkg::MABS_OP_COMPARE_IMM: begin
        aluB = immK;
      end
      mabs_pkg::MABS_OP_MINUS_BORROW,
      mabs_pkg::MABS_OP_COMPARE_C: begin
        aluCin   = q.sreg[mabs_pkg::FLAG_C];
        aluChain = 1'b1;
      end
      mabs_pkg::MABS_OP_MINUS_IMM_BR: begin
        aluB     = immK;
        aluCin   = q.sreg[mabs_pkg::FLAG_C];
        aluChain = 1'b1;
      end
      default: begin
        aluB = q.regs[srcIdx];
      end
    endcase
  end

  mabs_alu8 u_alu (
    .opA       (aluA),
    .opB       (aluB),
    .carryIn   (aluCin),
    .doSub     (aluSub),
    .chainZero (aluChain),
    .zeroPrev  (q.sreg[mabs_pkg::FLAG_Z]),
    .result    (aluRes),
    .flagH     (aluH),
    .flagV     (aluV),
    .flagN     (aluN),
    .flagZ     (aluZ),
    .flagC     (aluC)
  );

  // ==========================================================
  // execution of the issued operation
  always_comb begin
    ex          = '0;
    ex.idx      = dstIdx;
    ex.pc       = pcInc;
    ex.pushAddr = pcInc;
    ex.ioAddr   = ioAddr;
    ex.ioMask   = 8'(8'h01 << ioBit);
    ex.cyc      = mabs_pkg::CYC_ALU;
    logicRes    = 8'h00;
    wordSum     = 17'h00000;
    skipTaken   = 1'b0;
    case (opCode)
      mabs_pkg::MABS_OP_ADD,
      mabs_pkg::MABS_OP_ADD_CARRY,
      mabs_pkg::MABS_OP_MINUS,
      mabs_pkg::MABS_OP_MINUS_IMM,
      mabs_pkg::MABS_OP_MINUS_BORROW,
      mabs_pkg::MABS_OP_MINUS_IMM_BR: begin
        ex.wrEn     = 1'b1;
        ex.val      = {8'h00, aluRes};
        ex.flagMask = mabs_pkg::MASK_ARITH;
        ex.flags    = packFlags(aluH, 1'b0, aluV, aluN, aluZ, aluC);
      end
      mabs_pkg::MABS_OP_COMPARE,
      mabs_pkg::MABS_OP_COMPARE_C,
      mabs_pkg::MABS_OP_COMPARE_IMM: begin
        ex.flagMask = mabs_pkg::MASK_ARITH;
        ex.flags    = packFlags(aluH, 1'b0, aluV, aluN, aluZ, aluC);
      end
      mabs_pkg::MABS_OP_AND,
      mabs_pkg::MABS_OP_AND_IMM,
      mabs_pkg::MABS_OP_OR,
      mabs_pkg::MABS_OP_OR_IMM,
      mabs_pkg::MABS_OP_XOR,
      mabs_pkg::MABS_OP_SET_MASK,
      mabs_pkg::MABS_OP_CLEAR_MASK,
      mabs_pkg::MABS_OP_ZERO_CHECK: begin
        case (opCode)
          mabs_pkg::MABS_OP_AND:        logicRes = aluA & q.regs[srcIdx];
          mabs_pkg::MABS_OP_AND_IMM:    logicRes = aluA & immK;
          mabs_pkg::MABS_OP_OR:         logicRes = aluA | q.regs[srcIdx];
          mabs_pkg::MABS_OP_OR_IMM:     logicRes = aluA | immK;
          mabs_pkg::MABS_OP_XOR:        logicRes = aluA ^ q.regs[srcIdx];
          mabs_pkg::MABS_OP_SET_MASK:   logicRes = aluA | immK;
          mabs_pkg::MABS_OP_CLEAR_MASK: logicRes = aluA & (mabs_pkg::MASK_FULL ^ immK);
          default:                      logicRes = aluA & aluA;
        endcase
        ex.wrEn     = 1'b1;
        ex.val      = {8'h00, logicRes};
        ex.flagMask = mabs_pkg::MASK_LOGIC;
        ex.flags    = logicFlags(logicRes);
      end
      mabs_pkg::MABS_OP_WORD_ADD_IMM: begin
        wordSum     = {1'b0, wordIn} + {11'h000, immK[5:0]};
        ex.wrEn     = 1'b1;
        ex.wordEn   = 1'b1;
        ex.val      = wordSum[15:0];
        ex.flagMask = mabs_pkg::MASK_WORD;
        ex.flags    = packFlags(1'b0, wordSum[15] ^ (~wordIn[15] & wordSum[15]),
                                ~wordIn[15] & wordSum[15], wordSum[15],
                                wordSum[15:0] == 16'h0000, ~wordSum[15] & wordIn[15]);
        ex.cyc      = mabs_pkg::CYC_WORD;
      end
      mabs_pkg::MABS_OP_WORD_MINUS: begin
        wordSum     = {1'b0, wordIn} - {11'h000, immK[5:0]};
        ex.wrEn     = 1'b1;
        ex.wordEn   = 1'b1;
        ex.val      = wordSum[15:0];
        ex.flagMask = mabs_pkg::MASK_WORD;
        ex.flags    = packFlags(1'b0, wordSum[15] ^ (wordIn[15] & ~wordSum[15]),
                                wordIn[15] & ~wordSum[15], wordSum[15],
                                wordSum[15:0] == 16'h0000, wordSum[15] & ~wordIn[15]);
        ex.cyc      = mabs_pkg::CYC_WORD;
      end
      mabs_pkg::MABS_OP_REL_CALL: begin
        ex.pc   = PC_W'(q.pc + relOffset + 1'b1);
        ex.push = 1'b1;
        ex.cyc  = mabs_pkg::CYC_CALL;
      end
      mabs_pkg::MABS_OP_PTR_JUMP: begin
        ex.pc  = ptrVal[PC_W-1:0];
        ex.cyc = mabs_pkg::CYC_JUMP;
      end
      mabs_pkg::MABS_OP_PTR_CALL: begin
        ex.pc   = ptrVal[PC_W-1:0];
        ex.push = 1'b1;
        ex.cyc  = mabs_pkg::CYC_CALL;
      end
      mabs_pkg::MABS_OP_EQUAL_SKIP,
      mabs_pkg::MABS_OP_SKIP_IO_HIGH,
      mabs_pkg::MABS_OP_SKIP_IO_LOW: begin
        case (opCode)
          mabs_pkg::MABS_OP_EQUAL_SKIP:   skipTaken = aluA == q.regs[srcIdx];
          mabs_pkg::MABS_OP_SKIP_IO_HIGH: skipTaken = ioInRange & ioOperand[ioBit];
          default:                        skipTaken = ioInRange & ~ioOperand[ioBit];
        endcase
        if (skipTaken) begin
          ex.pc  = PC_W'(q.pc + (nextTwoWord ? 2'h3 : 2'h2));
          ex.cyc = nextTwoWord ? mabs_pkg::CYC_SKIP2 : mabs_pkg::CYC_SKIP1;
        end
      end
      mabs_pkg::MABS_OP_IO_BIT_SET,
      mabs_pkg::MABS_OP_IO_BIT_CLEAR: begin
        ex.ioEn   = ioInRange;
        ex.ioData = (opCode == mabs_pkg::MABS_OP_IO_BIT_SET) ? ex.ioMask : 8'h00;
        ex.cyc    = mabs_pkg::CYC_IOBIT;
      end
      default: begin
        ex.cyc = mabs_pkg::CYC_ALU;
      end
    endcase
  end

  // ==========================================================
  // sequencing and commit
  assign commit = (accept & (ex.cyc == mabs_pkg::CYC_ALU)) |
                  ((q.st == mabs_pkg::MABS_WAIT) & (q.cnt == 2'h1));
  assign src    = (q.st == mabs_pkg::MABS_IDLE) ? ex : q.pend;

  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.pushEn = 1'b0;
    d.ioWrEn = 1'b0;
    d.rdData = q.regs[rdIdx];
    case (q.st)
      mabs_pkg::MABS_IDLE: begin
        if (accept) begin
          d.pend = ex;
          if (ex.cyc != mabs_pkg::CYC_ALU) begin
            d.st   = mabs_pkg::MABS_WAIT;
            d.cnt  = 2'(ex.cyc - 2'h1);
            d.busy = 1'b1;
          end
        end else if (loadEn) begin
          d.regs[loadIdx] = loadData;
        end
      end
      mabs_pkg::MABS_WAIT: begin
        d.cnt = 2'(q.cnt - 2'h1);
      end
      default: begin
        d.st = mabs_pkg::MABS_IDLE;
      end
    endcase
    if (commit) begin
      if (src.wrEn) begin
        d.regs[src.idx] = src.val[7:0];
        if (src.wordEn) begin
          d.regs[5'(src.idx + 5'h01)] = src.val[15:8];
        end
      end
      d.sreg     = (q.sreg & ~src.flagMask) | (src.flags & src.flagMask);
      d.pc       = src.pc;
      d.pushEn   = src.push;
      d.pushAddr = src.pushAddr;
      d.ioWrEn   = src.ioEn;
      d.ioWrAddr = src.ioAddr;
      d.ioWrMask = src.ioMask;
      d.ioWrData = src.ioData;
      d.done     = 1'b1;
      d.busy     = 1'b0;
      d.st       = mabs_pkg::MABS_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q      <= '0;
      q.st   <= mabs_pkg::MABS_IDLE;
      q.regs <= {32{mabs_pkg::REG_RESET}};
      q.sreg <= mabs_pkg::SREG_RESET;
    end else begin
      q <= d;
    end
  end

  assign rdData   = q.rdData;
  assign busy     = q.busy;
  assign done     = q.done;
  assign pc       = q.pc;
  assign status   = q.sreg;
  assign pushEn   = q.pushEn;
  assign pushAddr = q.pushAddr;
  assign ioWrEn   = q.ioWrEn;
  assign ioWrAddr = q.ioWrAddr;
  assign ioWrMask = q.ioWrMask;
  assign ioWrData = q.ioWrData;

  // ==========================================================
  // checks
  AST_ADD_ONE_CLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode == mabs_pkg::MABS_OP_ADD |=> done && !busy
      && q.regs[$past(dstIdx)] == $past(aluRes))
    else $error("add did not finish in one clock");

  AST_WORD_TWO_CLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode == mabs_pkg::MABS_OP_WORD_ADD_IMM |=> busy && !done ##1 done && !busy)
    else $error("word add did not take two clocks");

  AST_CALL_THREE_CLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode == mabs_pkg::MABS_OP_REL_CALL |=> !done [*2] ##1 (done && pushEn
      && pc == PC_W'($past(q.pc, 3) + $past(relOffset, 3) + 1'b1)))
    else $error("relative call target or timing wrong");

  AST_PTR_JUMP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode == mabs_pkg::MABS_OP_PTR_JUMP |-> ##2 (done
      && pc == $past(ptrVal[PC_W-1:0], 2) && status == $past(status, 2)))
    else $error("pointer jump target or flags wrong");

  AST_LOGIC_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode inside {mabs_pkg::MABS_OP_AND, mabs_pkg::MABS_OP_OR_IMM,
      mabs_pkg::MABS_OP_XOR} |=> !status[mabs_pkg::FLAG_V]
      && status[mabs_pkg::FLAG_C] == $past(status[mabs_pkg::FLAG_C])
      && status[mabs_pkg::FLAG_H] == $past(status[mabs_pkg::FLAG_H]))
    else $error("logic op touched carry or half carry");

  AST_COMPARE_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode == mabs_pkg::MABS_OP_COMPARE |=> $stable(q.regs)
      && status[mabs_pkg::FLAG_Z] == ($past(aluA) == $past(aluB)))
    else $error("compare wrote a register or missed zero");

  AST_SKIP_DISTANCE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && opCode == mabs_pkg::MABS_OP_EQUAL_SKIP && aluA == q.regs[srcIdx]
      && !nextTwoWord |=> !done ##1 (done && pc == PC_W'($past(q.pc, 2) + 2'h2)))
    else $error("equal skip distance or timing wrong");

  AST_IO_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ioWrEn |-> ioWrAddr <= mabs_pkg::IO_BIT_MAX && $past(busy))
    else $error("bit write outside bit-accessible range");

  AST_IO_ONE_BIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ioWrEn |-> $onehot(ioWrMask) && (ioWrData & ~ioWrMask) == 8'h00)
    else $error("bit write touches more than one bit");

endmodule

// >>> test/mabs_core_tb.sv
// self-checking bench for the alu and branch datapath
`timescale 1ns/1ns
module mabs_core_tb;
  // ==========================================================
  // stimulus and observed signals
  logic                  clk_sys     = 1'b0;
  logic                  rst_n       = 1'b0;
  logic                  opValid     = 1'b0;
  mabs_pkg::mabs_op_type opCode      = mabs_pkg::MABS_OP_NOP;
  logic [4:0]            dstIdx      = 5'h00;
  logic [4:0]            srcIdx      = 5'h00;
  logic [7:0]            immK        = 8'h00;
  logic [11:0]           relOffset   = 12'h000;
  logic [5:0]            ioAddr      = 6'h00;
  logic [2:0]            ioBit       = 3'h0;
  logic [7:0]            ioOperand   = 8'h00;
  logic                  nextTwoWord = 1'b0;
  logic                  loadEn      = 1'b0;
  logic [4:0]            loadIdx     = 5'h00;
  logic [7:0]            loadData    = 8'h00;
  logic [4:0]            rdIdx       = 5'h00;
  logic [7:0]            rdData, status, ioWrMask, ioWrData, wMask, wData;
  logic [11:0]           pc, pushAddr, expPc, pAddr;
  logic [5:0]            ioWrAddr, wAddr;
  logic                  busy, done, pushEn, ioWrEn, pSeen, wSeen, bSeen;
  int                    failures    = 0;
  int                    tests_run   = 0;
  int                    cycles      = 0;

  mabs_core #(.PC_W(12)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
    .dstIdx(dstIdx), .srcIdx(srcIdx), .immK(immK), .relOffset(relOffset),
    .ioAddr(ioAddr), .ioBit(ioBit), .ioOperand(ioOperand), .nextTwoWord(nextTwoWord),
    .loadEn(loadEn), .loadIdx(loadIdx), .loadData(loadData), .rdIdx(rdIdx),
    .rdData(rdData), .busy(busy), .done(done), .pc(pc), .status(status),
    .pushEn(pushEn), .pushAddr(pushAddr), .ioWrEn(ioWrEn), .ioWrAddr(ioWrAddr),
    .ioWrMask(ioWrMask), .ioWrData(ioWrData)
  );

  // ==========================================================
  // clock and hang guard
  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic ld(input int i, input int v);
    @(negedge clk_sys);
    loadEn = 1'b1;
    loadIdx = i[4:0];
    loadData = v[7:0];
    @(negedge clk_sys);
    loadEn = 1'b0;
  endtask

  task automatic rd(input int i, output logic [7:0] v);
    @(negedge clk_sys);
    rdIdx = i[4:0];
    @(negedge clk_sys);
    v = rdData;
  endtask

  // issue one op, wait for done, check clock count, capture pulses
  task automatic go(input int o, input int d, input int s, input int k, input int c);
    int n;
    @(negedge clk_sys);
    opValid = 1'b1;
    opCode = mabs_pkg::mabs_op_type'(o[4:0]);
    dstIdx = d[4:0];
    srcIdx = s[4:0];
    immK = k[7:0];
    @(negedge clk_sys);
    opValid = 1'b0;
    bSeen = busy;
    n = 1;
    while (done !== 1'b1 && n < 9) begin
      @(negedge clk_sys);
      n++;
    end
    chk(16'(n), c[15:0]);
    pSeen = pushEn;
    pAddr = pushAddr;
    wSeen = ioWrEn;
    wAddr = ioWrAddr;
    wMask = ioWrMask;
    wData = ioWrData;
  endtask

  // op with expected clocks, pc step, register value and flags
  task automatic alu(input int o, input int d, input int s, input int k, input int c,
                     input int st, input int r, input int f);
    logic [7:0] v;
    go(o, d, s, k, c);
    expPc = expPc + st[11:0];
    chk({4'h0, pc}, {4'h0, expPc});
    chk({8'h00, status}, f[15:0]);
    rd(d, v);
    chk({8'h00, v}, r[15:0]);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_arith();
    ld(1, 'h0f);
    ld(2, 'h01);
    ld(3, 'hff);
    alu('h01, 1, 2, 0, 1, 1, 'h10, 'h20);
    chk({15'h0000, bSeen}, 16'h0000);
    alu('h01, 3, 2, 0, 1, 1, 'h00, 'h23);
    alu('h02, 1, 2, 0, 1, 1, 'h12, 'h00);
    alu('h05, 1, 0, 'h13, 1, 1, 'hff, 'h25);
    alu('h06, 1, 2, 0, 1, 1, 'hfd, 'h04);
    alu('h15, 1, 1, 0, 1, 1, 'hfd, 'h02);
    $display("t_arith finished");
  endtask

  task automatic t_logic();
    alu('h0a, 1, 0, 'h0f, 1, 1, 'h0d, 'h00);
    alu('h0f, 1, 0, 'h0d, 1, 1, 'h00, 'h02);
    alu('h0e, 1, 0, 'h80, 1, 1, 'h80, 'h04);
    alu('h0b, 1, 2, 0, 1, 1, 'h81, 'h04);
    alu('h0d, 1, 1, 0, 1, 1, 'h00, 'h02);
    alu('h10, 2, 2, 0, 1, 1, 'h01, 'h00);
    alu('h17, 2, 0, 'h02, 1, 1, 'h01, 'h25);
    alu('h16, 2, 3, 0, 1, 1, 'h01, 'h00);
    alu('h04, 3, 2, 0, 1, 1, 'hff, 'h25);
    alu('h07, 3, 0, 'h00, 1, 1, 'hfe, 'h04);
    alu('h09, 3, 2, 0, 1, 1, 'h00, 'h02);
    alu('h0c, 3, 0, 'h81, 1, 1, 'h81, 'h04);
    $display("t_logic finished");
  endtask

  task automatic t_word();
    logic [7:0] v;
    ld(24, 'hff);
    alu('h03, 24, 0, 'h01, 2, 1, 'h00, 'h00);
    chk({15'h0000, bSeen}, 16'h0001);
    rd(25, v);
    chk({8'h00, v}, 16'h0001);
    alu('h08, 26, 0, 'h01, 2, 1, 'hff, 'h15);
    rd(27, v);
    chk({8'h00, v}, 16'h00ff);
    $display("t_word finished");
  endtask

  task automatic t_branch();
    ld(30, 'h34);
    ld(31, 'h02);
    relOffset = 12'hffe;
    alu('h11, 2, 2, 0, 3, 'hfff, 'h01, 'h15);
    chk({pSeen, 3'h0, pAddr}, {4'h8, expPc + 12'h002});
    alu('h12, 2, 2, 0, 2, 'h234 - expPc, 'h01, 'h15);
    alu('h13, 2, 2, 0, 3, 0, 'h01, 'h15);
    chk({pSeen, 3'h0, pAddr}, {4'h8, 12'h235});
    $display("t_branch finished");
  endtask

  task automatic t_skip_io();
    alu('h14, 2, 2, 0, 2, 2, 'h01, 'h15);
    nextTwoWord = 1'b1;
    alu('h14, 2, 2, 0, 3, 3, 'h01, 'h15);
    alu('h14, 2, 3, 0, 1, 1, 'h01, 'h15);
    nextTwoWord = 1'b0;
    ioAddr = 6'h1f;
    ioBit = 3'h2;
    ioOperand = 8'h04;
    alu('h1a, 2, 2, 0, 2, 2, 'h01, 'h15);
    alu('h1b, 2, 2, 0, 1, 1, 'h01, 'h15);
    ioBit = 3'h3;
    ioOperand = 8'hf0;
    alu('h1b, 2, 2, 0, 2, 2, 'h01, 'h15);
    alu('h18, 2, 2, 0, 2, 1, 'h01, 'h15);
    chk({wSeen, 1'b0, wAddr, wMask}, {2'h2, 6'h1f, 8'h08});
    chk({8'h00, wData}, 16'h0008);
    ioBit = 3'h0;
    alu('h19, 2, 2, 0, 2, 1, 'h01, 'h15);
    chk({wSeen, 1'b0, wAddr, wMask}, {2'h2, 6'h1f, 8'h01});
    chk({8'h00, wData}, 16'h0000);
    ioAddr = 6'h20;
    alu('h18, 2, 2, 0, 2, 1, 'h01, 'h15);
    chk({15'h0000, wSeen}, 16'h0000);
    ioBit = 3'h4;
    alu('h1a, 2, 2, 0, 1, 1, 'h01, 'h15);
    $display("t_skip_io finished");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    expPc = 12'h000;
    repeat (6) @(negedge clk_sys);
    chk({4'h0, pc}, 16'h0000);
    chk({8'h00, status}, 16'h0000);
    rst_n = 1'b1;
    t_arith();
    t_logic();
    t_word();
    t_branch();
    t_skip_io();
    stop_test();
  end
endmodule
